//--- rtl/dpa_pkg.sv
// package: timing and encodings for the dual-port ram access controller
package dpa_pkg;
  // ==========================================================
  // timing
  localparam int CLK_NS         = 40;
  localparam int RC_NS          = 55;   // read_cycle_time, slowest grade
  localparam int PWE_NS         = 35;   // min_write_pulse
  localparam int SD_NS          = 20;   // data setup to write end
  localparam int HZWE_NS        = 25;   // write low to output high z
  localparam int SWRD_NS        = 15;   // flag write to read time
  localparam int SOP_NS         = 20;   // flag update pulse
  localparam int POWERUP_NS     = 1000; // supply settle before first access
  localparam int RC_CYC   = (RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWE_CYC  = (PWE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWEOE_CYC = (PWE_NS + HZWE_NS + SD_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC  = ((SWRD_NS > SOP_NS ? SWRD_NS : SOP_NS) + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_CYC = (POWERUP_NS + RC_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam logic [7:0] RESET_CNT = 8'h00;
  // ==========================================================
  // encodings
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SEMRQ = 2'h2; // request token, then read back
  localparam logic [1:0] OP_SEMRL = 2'h3; // release token
endpackage

//--- rtl/dpa_host.sv
// module: host controller driving one port of an asynchronous dual-port ram
`timescale 1ns/1ps
module dpa_host #(
  parameter int AW = 13  // address width
) (
  input  wire logic          clk,           // 25 mhz clock
  input  wire logic          rst,           // async reset, active high
  input  wire logic          req_valid,     // user request
  input  wire logic [1:0]    req_op,        // operation code
  input  wire logic [AW-1:0] req_addr,      // word or flag address
  input  wire logic [15:0]   req_wdata,     // write data
  input  wire logic [1:0]    req_lanes,     // bit1 upper, bit0 lower
  input  wire logic          retain,        // battery retention request
  output logic               req_ready,     // idle and accepting
  output logic               rsp_valid,     // one-cycle answer pulse
  output logic [15:0]        rsp_rdata,     // read data
  output logic               rsp_owned,     // token held after request
  output logic               rsp_busy,      // contention seen during access
  output logic [AW-1:0]      addr,          // device address
  output logic               port_select_n, // ram select
  output logic               semaphore_select_n, // flag latch select
  output logic               read_write_n,  // write enable, low writes
  output logic               output_drive_enable_n, // device output enable
  output logic               upper_lane_enable_n,   // upper byte lane
  output logic               lower_lane_enable_n,   // lower byte lane
  input  wire logic [15:0]   data_in,       // data pins as seen
  output logic [15:0]        data_out,      // data driven by host
  output logic               data_oe,       // high while host drives data
  input  wire logic          busy_n         // contention from device
);
  // ==========================================================
  // state
  typedef enum logic [6:0] {
    ST_PWRUP = 7'h01, ST_IDLE = 7'h02, ST_SETUP = 7'h04, ST_PULSE = 7'h08,
    ST_READ  = 7'h10, ST_GAP  = 7'h20, ST_RBACK = 7'h40
  } dpa_st_e;

  typedef struct packed {
    dpa_st_e         st;
    logic [7:0]      cnt;
    logic [1:0]      op;
    logic            ready, rv, owned, busy;
    logic [15:0]     rdata, dout;
    logic            oe;
    logic [AW-1:0]   a;
    logic            cs_n, sem_n, rw_n, oe_n, ub_n, lb_n;
  } dpa_s;

  dpa_s st_ff, nxt_st;

  // flag addresses need three bits; the port widths stop at sixteen
  if (AW < 3 || AW > 16) begin : g_aw_check
    $error("dpa_host: AW out of range");
  end

  function automatic logic is_sem(input logic [1:0] op);
    return op == dpa_pkg::OP_SEMRQ || op == dpa_pkg::OP_SEMRL;
  endfunction

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.rv = 1'b0;
    if (st_ff.cnt != dpa_pkg::RESET_CNT) nxt_st.cnt = st_ff.cnt - 8'h01;
    case (st_ff.st)
      ST_PWRUP: begin
        if (st_ff.cnt == dpa_pkg::RESET_CNT) begin
          nxt_st.st    = ST_IDLE;
          nxt_st.ready = !retain;
        end
      end
      ST_IDLE: begin
        nxt_st.ready = !retain;
        nxt_st.cs_n  = 1'b1;
        nxt_st.sem_n = 1'b1;
        if (req_valid && st_ff.ready && !retain) begin
          nxt_st.ready = 1'b0;
          nxt_st.op    = req_op;
          nxt_st.a     = req_addr;
          nxt_st.busy  = 1'b0;
          // select before write low so the write window is select-bounded
          nxt_st.cs_n  = is_sem(req_op);
          nxt_st.sem_n = !is_sem(req_op);
          nxt_st.ub_n  = is_sem(req_op) ? 1'b1 : !req_lanes[1];
          nxt_st.lb_n  = is_sem(req_op) ? 1'b1 : !req_lanes[0];
          nxt_st.rw_n  = 1'b1;
          if (req_op == dpa_pkg::OP_READ) begin
            nxt_st.oe_n = 1'b0;
            nxt_st.st   = ST_READ;
            nxt_st.cnt  = 8'(dpa_pkg::RC_CYC);
          end else begin
            nxt_st.oe_n = 1'b1;  // short pulse allowed with outputs off
            nxt_st.st   = ST_SETUP;
            nxt_st.dout = req_op == dpa_pkg::OP_SEMRQ ? 16'hfffe :
                          req_op == dpa_pkg::OP_SEMRL ? 16'hffff : req_wdata;
          end
        end
      end
      ST_SETUP: begin
        nxt_st.oe   = 1'b1;  // outputs are off, host may drive
        nxt_st.rw_n = 1'b0;
        nxt_st.st   = ST_PULSE;
        nxt_st.cnt  = 8'(dpa_pkg::PWE_CYC);
      end
      ST_PULSE: begin
        if (!busy_n) nxt_st.busy = 1'b1;
        if (st_ff.cnt == dpa_pkg::RESET_CNT) begin
          nxt_st.rw_n  = 1'b1;
          nxt_st.cs_n  = 1'b1;
          nxt_st.sem_n = 1'b1;
          nxt_st.ub_n  = 1'b1;
          nxt_st.lb_n  = 1'b1;
          nxt_st.st    = ST_GAP;
          nxt_st.cnt   = 8'(dpa_pkg::GAP_CYC);
        end
      end
      ST_GAP: begin
        nxt_st.oe = 1'b0;
        if (st_ff.cnt == dpa_pkg::RESET_CNT) begin
          if (st_ff.op == dpa_pkg::OP_SEMRQ) begin
            // fresh flag select for each read back
            nxt_st.sem_n = 1'b0;
            nxt_st.oe_n  = 1'b0;
            nxt_st.st    = ST_RBACK;
            nxt_st.cnt   = 8'(dpa_pkg::RC_CYC);
          end else begin
            nxt_st.rv    = 1'b1;
            nxt_st.owned = 1'b0;
            nxt_st.st    = ST_IDLE;
          end
        end
      end
      ST_READ, ST_RBACK: begin
        if (!busy_n) nxt_st.busy = 1'b1;
        if (st_ff.cnt == dpa_pkg::RESET_CNT) begin
          nxt_st.rdata = data_in;
          nxt_st.owned = st_ff.st == ST_RBACK && !data_in[0];
          nxt_st.rv    = 1'b1;
          nxt_st.oe_n  = 1'b1;
          nxt_st.cs_n  = 1'b1;
          nxt_st.sem_n = 1'b1;
          nxt_st.ub_n  = 1'b1;
          nxt_st.lb_n  = 1'b1;
          nxt_st.st    = ST_IDLE;
        end
      end
      default: nxt_st.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff       <= '0;
      st_ff.st    <= ST_PWRUP;
      st_ff.cnt   <= 8'(dpa_pkg::PWRUP_CYC);
      st_ff.cs_n  <= 1'b1;
      st_ff.sem_n <= 1'b1;
      st_ff.rw_n  <= 1'b1;
      st_ff.oe_n  <= 1'b1;
      st_ff.ub_n  <= 1'b1;
      st_ff.lb_n  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign req_ready             = st_ff.ready;
  assign rsp_valid             = st_ff.rv;
  assign rsp_rdata             = st_ff.rdata;
  assign rsp_owned             = st_ff.owned;
  assign rsp_busy              = st_ff.busy;
  assign addr                  = st_ff.a;
  assign port_select_n         = st_ff.cs_n;
  assign semaphore_select_n    = st_ff.sem_n;
  assign read_write_n          = st_ff.rw_n;
  assign output_drive_enable_n = st_ff.oe_n;
  assign upper_lane_enable_n   = st_ff.ub_n;
  assign lower_lane_enable_n   = st_ff.lb_n;
  assign data_out              = st_ff.dout;
  assign data_oe               = st_ff.oe;

  // ==========================================================
  // checks
  sequence wr_start_s;
    st_ff.st == ST_SETUP;
  endsequence
  sequence wr_low_s;
    !read_write_n && data_oe;
  endsequence

  property no_drive_on_read;
    @(posedge clk) disable iff (rst) !output_drive_enable_n |-> !data_oe;
  endproperty
  drive_clash_a: assert property (no_drive_on_read)
    else $error("host drives data while device outputs enabled");

  read_hold_a: assert property (@(posedge clk) disable iff (rst)
    (st_ff.st == ST_READ) |-> read_write_n)
    else $error("write enable low during read");

  sel_exclusive_a: assert property (@(posedge clk) disable iff (rst)
    !(port_select_n == 1'b0 && semaphore_select_n == 1'b0))
    else $error("ram and flag selected together");

  write_pulse_a: assert property (@(posedge clk) disable iff (rst)
    wr_start_s |=> wr_low_s [*2])
    else $error("write pulse shorter than two cycles");

  pwrup_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (st_ff.st == ST_PWRUP) |-> (port_select_n && semaphore_select_n))
    else $error("access during power-up");

  retain_sel_a: assert property (@(posedge clk) disable iff (rst)
    (retain && st_ff.st == ST_IDLE) |=> port_select_n)
    else $error("ram selected during retention");

  req_bit_a: assert property (@(posedge clk) disable iff (rst)
    (st_ff.st == ST_PULSE && st_ff.op == dpa_pkg::OP_SEMRQ) |-> !data_out[0])
    else $error("token request without bit zero low");

  lane_sel_a: assert property (@(posedge clk) disable iff (rst)
    (!upper_lane_enable_n || !lower_lane_enable_n) |-> !port_select_n)
    else $error("lane enabled without ram select");

  fresh_sel_a: assert property (@(posedge clk) disable iff (rst)
    (st_ff.st == ST_RBACK && $past(st_ff.st) != ST_RBACK) |-> $past(semaphore_select_n)
      && !semaphore_select_n)
    else $error("flag read without flag select");
endmodule

//--- verif/dpa_dev.sv
// device model: one port of the dual-port ram and its flag latches
`timescale 1ns/1ps
module dpa_dev (
  input  wire logic        clk,                   // bench clock
  input  wire logic [12:0] addr,                  // address
  input  wire logic        port_select_n,         // ram select
  input  wire logic        semaphore_select_n,    // flag select
  input  wire logic        read_write_n,          // low writes
  input  wire logic        output_drive_enable_n, // output enable
  input  wire logic        upper_lane_enable_n,   // upper lane
  input  wire logic        lower_lane_enable_n,   // lower lane
  input  wire logic [15:0] data_out,              // host data
  input  wire logic        data_oe,               // host drives
  input  wire logic [7:0]  other_hold,            // far port tokens
  input  wire logic        match_en,              // far port same addr
  output logic      [15:0] data_in,               // pin level
  output logic             busy_n,                // contention
  output logic             clash,                 // both drove pins
  output logic             mbox_flag_n            // mailbox word written
);
  // ==========
  // array, latches and pins
  logic [15:0] mem [0:8191];
  logic [7:0]  own = 8'h00;
  logic [15:0] junk = 16'h5a5a;
  logic        ram_sel;
  logic        sem_sel;
  logic        dev_oe;
  initial clash = 1'b0;
  initial mbox_flag_n = 1'b1;
  assign ram_sel = !port_select_n && semaphore_select_n;
  assign sem_sel = port_select_n && !semaphore_select_n;
  assign dev_oe = (ram_sel || sem_sel) && read_write_n && !output_drive_enable_n;
  assign busy_n = !(match_en && !port_select_n);
  always @* begin
    if (!read_write_n && data_oe && ram_sel && !upper_lane_enable_n) mem[addr][15:8] = data_out[15:8];
    if (!read_write_n && data_oe && ram_sel && !lower_lane_enable_n) mem[addr][7:0] = data_out[7:0];
    // far port keeps a held token, so a request only wins a free latch
    if (!read_write_n && data_oe && sem_sel) own[addr[2:0]] = !data_out[0] && (own[addr[2:0]] || !other_hold[addr[2:0]]);
    // mailbox word at the top address; set from whichever strobe comes last
    if (!read_write_n && ram_sel && addr == 13'h1fff) mbox_flag_n = 1'b0;
    else if (dev_oe && ram_sel && addr == 13'h1fff) mbox_flag_n = 1'b1;
  end
  always @* begin
    if (data_oe) data_in = data_out;
    else if (dev_oe && sem_sel) data_in = {16{!own[addr[2:0]]}};
    else if (dev_oe) data_in = {upper_lane_enable_n ? junk[15:8] : mem[addr][15:8], lower_lane_enable_n ? junk[7:0] : mem[addr][7:0]};
    else data_in = junk;
  end
  // released pins change every cycle so a stale sample cannot match
  always @(posedge clk) begin
    junk <= ~data_in;
    if (data_oe && dev_oe) clash <= 1'b1;
  end
endmodule

//--- verif/dpa_host_tb.sv
// testbench: access controller against the device model
`timescale 1ns/1ps
module dpa_host_tb;
  typedef struct packed {
    logic [1:0]  op;
    logic [12:0] a;
    logic [15:0] wd;
    logic [15:0] er;
    logic [1:0]  ln;
    logic        bz;
    logic        eo;
  } dpa_row_s;
  dpa_row_s rows [11] = '{
    '{2'h1, 13'h5, 16'h1234, 16'h0, 2'h3, 1'b0, 1'b0}, '{2'h0, 13'h5, 16'h0, 16'h1234, 2'h3, 1'b0, 1'b0},
    '{2'h1, 13'h5, 16'habcd, 16'h0, 2'h1, 1'b0, 1'b0}, '{2'h0, 13'h5, 16'h0, 16'h12cd, 2'h3, 1'b0, 1'b0},
    '{2'h1, 13'h5, 16'h5600, 16'h0, 2'h2, 1'b0, 1'b0}, '{2'h0, 13'h5, 16'h0, 16'h56cd, 2'h3, 1'b1, 1'b0},
    '{2'h1, 13'h1fff, 16'h0001, 16'h0, 2'h3, 1'b0, 1'b0}, '{2'h0, 13'h1fff, 16'h0, 16'h0001, 2'h3, 1'b0, 1'b0},
    '{2'h2, 13'h2, 16'h0, 16'h0, 2'h3, 1'b0, 1'b1}, '{2'h2, 13'h3, 16'h0, 16'h0, 2'h3, 1'b0, 1'b0},
    '{2'h3, 13'h2, 16'h0, 16'h0, 2'h3, 1'b0, 1'b0}};
  logic clk, rst, req_valid, retain, req_ready, rsp_valid, rsp_owned, rsp_busy, data_oe;
  logic port_select_n, semaphore_select_n, read_write_n, output_drive_enable_n;
  logic upper_lane_enable_n, lower_lane_enable_n, busy_n, match_en, clash, mbox_flag_n;
  logic [1:0]  req_op;
  logic [1:0]  req_lanes;
  logic [12:0] req_addr;
  logic [12:0] addr;
  logic [15:0] req_wdata, rsp_rdata, data_in, data_out;
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  dpa_host #(.AW(13)) i_dut (.clk, .rst, .req_valid, .req_op, .req_addr, .req_wdata,
    .req_lanes, .retain, .req_ready, .rsp_valid, .rsp_rdata, .rsp_owned, .rsp_busy, .addr,
    .port_select_n, .semaphore_select_n, .read_write_n, .output_drive_enable_n,
    .upper_lane_enable_n, .lower_lane_enable_n, .data_in, .data_out, .data_oe, .busy_n);
  dpa_dev i_dev (.clk, .addr, .port_select_n, .semaphore_select_n, .read_write_n,
    .output_drive_enable_n, .upper_lane_enable_n, .lower_lane_enable_n, .data_out, .data_oe,
    .other_hold(8'h08), .match_en, .data_in, .busy_n, .clash, .mbox_flag_n);
  // ==========
  // shared tasks
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_for(input bit rdy);
    n = 0;
    while ((rdy ? req_ready : rsp_valid) !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 200) begin
      fail_count++;
      stop_test();
    end
  endtask
  task automatic do_op(input dpa_row_s r);
    match_en = r.bz;
    wait_for(1'b1);
    req_op = r.op;
    req_addr = r.a;
    req_wdata = r.wd;
    req_lanes = r.ln;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    wait_for(1'b0);
    check("rsp_valid", {15'h0, rsp_valid}, 16'h0001);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 4000);
    fail_count++;
    stop_test();
  end
  // ==========
  // tests
  initial begin
    {rst, req_valid, retain, match_en, req_op, req_lanes, req_addr, req_wdata} = {1'b1, 36'h0};
    repeat (4) @(posedge clk);
    #1;
    check("reset pins", {12'h0, port_select_n, semaphore_select_n, read_write_n, req_ready}, 16'h000e);
    rst = 1'b0;
    wait_for(1'b1);
    check("powerup", {15'h0, n >= dpa_pkg::PWRUP_CYC}, 16'h0001);
    $display("test reset done");
    foreach (rows[i]) begin
      do_op(rows[i]);
      if (rows[i].op == 2'h0) check("rdata", rsp_rdata, rows[i].er);
      if (rows[i].op == 2'h2) check("owned", {15'h0, rsp_owned}, {15'h0, rows[i].eo});
      check("busy", {15'h0, rsp_busy}, {15'h0, rows[i].bz});
      if (rows[i].a == 13'h1fff) check("mailbox", {15'h0, mbox_flag_n}, {15'h0, rows[i].op != 2'h1});
    end
    $display("test rows done");
    retain = 1'b1;
    req_op = 2'h0;
    req_valid = 1'b1;
    repeat (8) begin
      @(posedge clk);
      #1;
      check("retain", {13'h0, port_select_n, rsp_valid, req_ready}, 16'h0004);
    end
    {retain, req_valid} = 2'b00;
    do_op(rows[3]);
    check("rdata", rsp_rdata, 16'h56cd);
    $display("test retain done");
    req_valid = 1'b1;
    req_op = 2'h1;
    repeat (2) @(posedge clk);
    #1;
    {rst, req_valid} = 2'b10;
    @(posedge clk);
    #1;
    check("mid reset", {13'h0, port_select_n, read_write_n, data_oe}, 16'h0006);
    rst = 1'b0;
    do_op(rows[5]);
    check("rdata", rsp_rdata, 16'h56cd);
    check("clash", {15'h0, clash}, 16'h0000);
    $display("test mid reset done");
    stop_test();
  end
endmodule
